// [hdl/rsq_params.svh]
// Constants for the sequence table stepper
`ifndef RSQ_PARAMS_SVH
`define RSQ_PARAMS_SVH
`define RSQ_ENTRIES      10
`define RSQ_LAST_ENTRY   4'h9
`define RSQ_LINK_OFF     4'hf
`define RSQ_MAX_WIDTH    13'h1400
`define RSQ_MIN_WIDTH    13'h0008
`define RSQ_HALF_WIDTH   13'h0a00
`define RSQ_MAX_HEIGHT   12'hf00
`define RSQ_MIN_HEIGHT   12'h002
`define RSQ_HALF_HEIGHT  12'h780
`define RSQ_MIN_EXPOSURE 20'h0000a
`define RSQ_BLACK_MIN    (-10'sd256)
`define RSQ_BLACK_MAX    (10'sd255)
`define RSQ_MERGE_OFF    2'h1
`define RSQ_MERGE_ON     2'h2
`define RSQ_RST_GAIN     16'h0064
`define RSQ_RST_EXPOSURE 20'h2bf20
`define RSQ_RST_COUNT    8'h01
`define RSQ_RST_LINK     4'h0
`define RSQ_RST_REPEAT   8'h01
`endif

// [hdl/rsq_pkg.sv]
// Types for the sequence table stepper
package rsq_pkg;
  typedef enum logic [1:0] {
    RSQ_MODE_NORMAL,
    RSQ_MODE_TRIG_SEQ,
    RSQ_MODE_CMD_SEQ,
    RSQ_MODE_MULTI
  } rsq_mode_type;
  typedef enum logic [2:0] {
    RSQ_FLD_SIZE,
    RSQ_FLD_OFFSET,
    RSQ_FLD_GAIN,
    RSQ_FLD_EXPOSURE,
    RSQ_FLD_BLACK,
    RSQ_FLD_FLAGS,
    RSQ_FLD_STEP
  } rsq_field_type;
endpackage

// [hdl/rsq_pin_sync.sv]
// Three-stage pin synchroniser with agreement filter
module rsq_pin_sync (
  // Clock
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic clk_en,
  // Pin
  input  wire logic pin_in,
  output logic      level_out
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s1_q      <= 1'b0;
      s2_q      <= 1'b0;
      s3_q      <= 1'b0;
      level_out <= 1'b0;
    end else if (clk_en) begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_out <= s3_q;
      end
    end
  end
endmodule

// [hdl/rsq_sequencer.sv]
// Sequence table stepper: ten capture entries stepped by an external trigger
`include "rsq_params.svh"
module rsq_sequencer #(
  parameter int ENTRIES = `RSQ_ENTRIES
) (
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  reset,
  input  wire logic                  clk_en,
  // Control
  input  wire rsq_pkg::rsq_mode_type send_mode,
  input  wire logic                  acq_start,
  input  wire logic [7:0]            seq_repeat,
  input  wire logic                  color_variant,
  input  wire logic                  op_busy,
  // Frame trigger pin
  input  wire logic                  trigger_pin,
  // Host command for command sequence mode
  input  wire logic                  next_cmd_valid,
  input  wire logic [3:0]            next_cmd_entry,
  // Table write port
  input  wire logic [3:0]            table_entry_pick,
  input  wire logic                  wr_en,
  input  wire rsq_pkg::rsq_field_type wr_field,
  input  wire logic [47:0]           wr_data,
  output logic                       wr_reject,
  // Table read port
  output logic [12:0]                rd_width,
  output logic [11:0]                rd_height,
  output logic [12:0]                rd_offset_x,
  output logic [11:0]                rd_offset_y,
  // Applied capture settings
  output logic                       frame_go,
  output logic [3:0]                 cur_entry,
  output logic [12:0]                cap_width,
  output logic [11:0]                cap_height,
  output logic [12:0]                cap_offset_x,
  output logic [11:0]                cap_offset_y,
  output logic [15:0]                cap_gain_all,
  output logic [15:0]                cap_gain_red,
  output logic [15:0]                cap_gain_blue,
  output logic [19:0]                cap_exposure,
  output logic [9:0]                 cap_black,
  output logic                       cap_lookup_en,
  output logic [1:0]                 cap_column_merge,
  output logic [1:0]                 cap_row_merge,
  // Status
  output logic                       acq_active,
  output logic [7:0]                 repeat_left
);
  import rsq_pkg::*;

  logic [12:0] width_q    [ENTRIES];
  logic [11:0] height_q   [ENTRIES];
  logic [12:0] offx_q     [ENTRIES];
  logic [11:0] offy_q     [ENTRIES];
  logic [15:0] gain_q     [ENTRIES];
  logic [15:0] red_q      [ENTRIES];
  logic [15:0] blue_q     [ENTRIES];
  logic [19:0] expo_q     [ENTRIES];
  logic [9:0]  black_q    [ENTRIES];
  logic        entry_lookup_enable [ENTRIES];
  logic [1:0]  entry_column_merge  [ENTRIES];
  logic [1:0]  entry_row_merge     [ENTRIES];
  logic [7:0]  entry_repeat_count  [ENTRIES];
  logic [3:0]  entry_follow_link   [ENTRIES];

  logic [3:0]  ptr_q;
  logic [7:0]  frames_q;
  logic [7:0]  rep_q;
  logic [3:0]  cmd_q;
  logic        run_q;
  logic        trig_lvl;
  logic        trig_prev_q;
  logic        trig_edge;
  logic        seq_mode;
  logic        pick_ok;
  logic [3:0]  pick;
  logic        field_ok;

  rsq_pin_sync u_trig_sync (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .clk_en    (clk_en),
    .pin_in    (trigger_pin),
    .level_out (trig_lvl)
  );

  assign seq_mode  = (send_mode == RSQ_MODE_TRIG_SEQ) || (send_mode == RSQ_MODE_CMD_SEQ);
  assign trig_edge = trig_lvl && !trig_prev_q;
  assign pick_ok   = (table_entry_pick <= `RSQ_LAST_ENTRY);
  assign pick      = pick_ok ? table_entry_pick : 4'h0;

  // Range check of a write against the addressed entry
  always_comb begin
    logic [12:0] xlim;
    logic [11:0] ylim;
    xlim     = 13'h0000;
    ylim     = 12'h000;
    field_ok = 1'b1;
    unique case (wr_field)
      RSQ_FLD_SIZE: begin
        field_ok = (wr_data[12:0] >= `RSQ_MIN_WIDTH) && (wr_data[12:0] <= `RSQ_MAX_WIDTH)
                && (wr_data[27:16] >= `RSQ_MIN_HEIGHT) && (wr_data[27:16] <= `RSQ_MAX_HEIGHT);
      end
      RSQ_FLD_OFFSET: begin
        xlim = (entry_column_merge[pick] == `RSQ_MERGE_ON) ? `RSQ_HALF_WIDTH : `RSQ_MAX_WIDTH;
        ylim = (entry_row_merge[pick] == `RSQ_MERGE_ON) ? `RSQ_HALF_HEIGHT : `RSQ_MAX_HEIGHT;
        field_ok = (width_q[pick] <= xlim) && (wr_data[12:0] <= xlim - width_q[pick])
                && (height_q[pick] <= ylim) && (wr_data[27:16] <= ylim - height_q[pick]);
      end
      RSQ_FLD_EXPOSURE: begin
        field_ok = (wr_data[19:0] >= `RSQ_MIN_EXPOSURE);
      end
      RSQ_FLD_BLACK: begin
        field_ok = ($signed(wr_data[9:0]) >= `RSQ_BLACK_MIN) && ($signed(wr_data[9:0]) <= `RSQ_BLACK_MAX);
      end
      RSQ_FLD_FLAGS: begin
        field_ok = (wr_data[2:1] == `RSQ_MERGE_OFF || wr_data[2:1] == `RSQ_MERGE_ON)
                && (wr_data[4:3] == `RSQ_MERGE_OFF || wr_data[4:3] == `RSQ_MERGE_ON);
      end
      RSQ_FLD_STEP: begin
        field_ok = (wr_data[7:0] != 8'h00)
                && (wr_data[11:8] <= `RSQ_LAST_ENTRY || wr_data[11:8] == `RSQ_LINK_OFF);
      end
      default: field_ok = 1'b1;
    endcase
  end

  // Table storage
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      for (int i = 0; i < ENTRIES; i++) begin
        width_q[i]             <= `RSQ_MAX_WIDTH;
        height_q[i]            <= `RSQ_MAX_HEIGHT;
        offx_q[i]              <= 13'h0000;
        offy_q[i]              <= 12'h000;
        gain_q[i]              <= `RSQ_RST_GAIN;
        red_q[i]               <= 16'h0000;
        blue_q[i]              <= 16'h0000;
        expo_q[i]              <= `RSQ_RST_EXPOSURE;
        black_q[i]             <= 10'h000;
        entry_lookup_enable[i] <= 1'b0;
        entry_column_merge[i]  <= `RSQ_MERGE_OFF;
        entry_row_merge[i]     <= `RSQ_MERGE_OFF;
        entry_repeat_count[i]  <= `RSQ_RST_COUNT;
        entry_follow_link[i]   <= `RSQ_RST_LINK;
      end
      wr_reject <= 1'b0;
    end else if (clk_en) begin
      wr_reject <= wr_en && !(pick_ok && field_ok);
      if (wr_en && pick_ok && field_ok) begin
        unique case (wr_field)
          RSQ_FLD_SIZE: begin
            width_q[pick]  <= wr_data[12:0];
            height_q[pick] <= wr_data[27:16];
          end
          RSQ_FLD_OFFSET: begin
            offx_q[pick] <= wr_data[12:0];
            offy_q[pick] <= wr_data[27:16];
          end
          RSQ_FLD_GAIN: begin
            gain_q[pick] <= wr_data[15:0];
            if (color_variant) begin
              red_q[pick]  <= wr_data[31:16];
              blue_q[pick] <= wr_data[47:32];
            end
          end
          RSQ_FLD_EXPOSURE: expo_q[pick] <= wr_data[19:0];
          RSQ_FLD_BLACK:    black_q[pick] <= wr_data[9:0];
          RSQ_FLD_FLAGS: begin
            entry_lookup_enable[pick] <= wr_data[0];
            entry_column_merge[pick]  <= wr_data[2:1];
            entry_row_merge[pick]     <= wr_data[4:3];
          end
          RSQ_FLD_STEP: begin
            entry_repeat_count[pick] <= wr_data[7:0];
            entry_follow_link[pick]  <= wr_data[11:8];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Read back of the picked entry's window
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rd_width    <= 13'h0000;
      rd_height   <= 12'h000;
      rd_offset_x <= 13'h0000;
      rd_offset_y <= 12'h000;
    end else if (clk_en) begin
      rd_width    <= width_q[pick];
      rd_height   <= height_q[pick];
      rd_offset_x <= offx_q[pick];
      rd_offset_y <= offy_q[pick];
    end
  end

  // Host entry command, latched until replaced or cleared to entry zero by a start
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cmd_q <= 4'h0;
    end else if (clk_en) begin
      if (acq_start) begin
        cmd_q <= 4'h0;
      end else if (next_cmd_valid && next_cmd_entry <= `RSQ_LAST_ENTRY) begin
        cmd_q <= next_cmd_entry;
      end
    end
  end

  // Stepping of the current entry
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      trig_prev_q <= 1'b0;
      ptr_q       <= 4'h0;
      frames_q    <= 8'h00;
      rep_q       <= `RSQ_RST_REPEAT;
      run_q       <= 1'b0;
      frame_go    <= 1'b0;
      cur_entry   <= 4'h0;
    end else if (clk_en) begin
      trig_prev_q <= trig_lvl;
      frame_go    <= 1'b0;
      if (acq_start) begin
        ptr_q    <= 4'h0;
        frames_q <= 8'h00;
        rep_q    <= (seq_repeat == 8'h00) ? `RSQ_RST_REPEAT : seq_repeat;
        run_q    <= 1'b1;
      end else if (trig_edge && run_q && seq_mode) begin
        if (send_mode == RSQ_MODE_CMD_SEQ) begin
          frame_go  <= 1'b1;
          cur_entry <= cmd_q;
        end else if (!op_busy) begin
          frame_go  <= 1'b1;
          cur_entry <= ptr_q;
          if (frames_q + 8'h01 >= entry_repeat_count[ptr_q]) begin
            frames_q <= 8'h00;
            if (entry_follow_link[ptr_q] == `RSQ_LINK_OFF) begin
              ptr_q <= 4'h0;
              rep_q <= rep_q - 8'h01;
              if (rep_q == 8'h01) begin
                run_q <= 1'b0;
              end
            end else begin
              ptr_q <= entry_follow_link[ptr_q];
            end
          end else begin
            frames_q <= frames_q + 8'h01;
          end
        end
      end
    end
  end

  // Settings applied with each accepted trigger
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cap_width        <= `RSQ_MAX_WIDTH;
      cap_height       <= `RSQ_MAX_HEIGHT;
      cap_offset_x     <= 13'h0000;
      cap_offset_y     <= 12'h000;
      cap_gain_all     <= `RSQ_RST_GAIN;
      cap_gain_red     <= 16'h0000;
      cap_gain_blue    <= 16'h0000;
      cap_exposure     <= `RSQ_RST_EXPOSURE;
      cap_black        <= 10'h000;
      cap_lookup_en    <= 1'b0;
      cap_column_merge <= `RSQ_MERGE_OFF;
      cap_row_merge    <= `RSQ_MERGE_OFF;
    end else if (clk_en && frame_go) begin
      cap_width        <= width_q[cur_entry];
      cap_height       <= height_q[cur_entry];
      cap_offset_x     <= offx_q[cur_entry];
      cap_offset_y     <= offy_q[cur_entry];
      cap_gain_all     <= gain_q[cur_entry];
      cap_gain_red     <= red_q[cur_entry];
      cap_gain_blue    <= blue_q[cur_entry];
      cap_exposure     <= expo_q[cur_entry];
      cap_black        <= black_q[cur_entry];
      cap_lookup_en    <= entry_lookup_enable[cur_entry];
      cap_column_merge <= entry_column_merge[cur_entry];
      cap_row_merge    <= entry_row_merge[cur_entry];
    end
  end

  // Status outputs
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      acq_active  <= 1'b0;
      repeat_left <= 8'h00;
    end else if (clk_en) begin
      acq_active  <= run_q;
      repeat_left <= rep_q;
    end
  end
endmodule

// [verif/rsq_checker.sv]
// Port assertions for the sequence table stepper
module rsq_checker #(
  parameter int ENTRIES = 10
) (
  // Clock and control
  input wire logic                   clk_sys,
  input wire logic                   reset,
  input wire rsq_pkg::rsq_mode_type  send_mode,
  input wire logic                   acq_start,
  input wire logic [7:0]             seq_repeat,
  input wire logic                   op_busy,
  // Table write
  input wire logic [3:0]             table_entry_pick,
  input wire logic                   wr_en,
  input wire rsq_pkg::rsq_field_type wr_field,
  input wire logic [47:0]            wr_data,
  input wire logic                   wr_reject,
  // Results
  input wire logic                   frame_go,
  input wire logic [3:0]             cur_entry,
  input wire logic [19:0]            cap_exposure,
  input wire logic                   acq_active,
  input wire logic [7:0]             repeat_left
);
  timeunit 1ns;
  timeprecision 100ps;
  import rsq_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic first_q;
  // Set from acquisition start until the first frame
  always_ff @(posedge clk_sys) begin
    if (reset) first_q <= 1'b0;
    else if (acq_start) first_q <= 1'b1;
    else if (frame_go) first_q <= 1'b0;
  end
  logic [7:0] load_q;
  // Repetition value that a start should load, zero counting as one
  always_ff @(posedge clk_sys) begin
    if (reset) load_q <= 8'h01;
    else if (acq_start) load_q <= (seq_repeat == 8'h00) ? 8'h01 : seq_repeat;
  end
  AST_RUN_ONLY: assert property (frame_go |-> $past(acq_active))
    else $error("frame started outside a run");
  AST_SEQ_MODE: assert property (frame_go |-> $past(send_mode) inside {RSQ_MODE_TRIG_SEQ, RSQ_MODE_CMD_SEQ})
    else $error("frame started outside sequence modes");
  AST_BUSY_REFUSE: assert property (frame_go && send_mode == RSQ_MODE_TRIG_SEQ |-> !$past(op_busy))
    else $error("trigger taken while busy");
  AST_ENTRY_RANGE: assert property (frame_go |-> cur_entry < ENTRIES)
    else $error("entry out of range");
  AST_FIRST_ZERO: assert property (frame_go && first_q && send_mode == RSQ_MODE_TRIG_SEQ |-> cur_entry == 4'h0)
    else $error("first frame not entry zero");
  AST_CAP_HOLD: assert property (!frame_go |=> $stable(cap_exposure))
    else $error("exposure changed without a frame");
  AST_PICK_REJECT: assert property (wr_en && table_entry_pick > 4'h9 |=> wr_reject)
    else $error("write to missing entry taken");
  AST_EXP_REJECT: assert property (wr_en && wr_field == RSQ_FLD_EXPOSURE && wr_data[19:0] < 20'h0000a |=> wr_reject)
    else $error("short exposure taken");
  AST_REJECT_CAUSE: assert property (wr_reject |-> $past(wr_en))
    else $error("reject without a write");
  AST_STOP_ZERO: assert property ($fell(acq_active) |-> repeat_left == 8'h00)
    else $error("run stopped with repetitions left");
  AST_START_LOAD: assert property (acq_start |-> ##2 (acq_active && repeat_left == load_q))
    else $error("start did not load repetition");
endmodule
bind rsq_sequencer rsq_checker #(.ENTRIES(ENTRIES)) chk_u (.clk_sys, .reset, .send_mode, .acq_start, .seq_repeat,
  .op_busy, .table_entry_pick, .wr_en, .wr_field, .wr_data, .wr_reject, .frame_go, .cur_entry, .cap_exposure,
  .acq_active, .repeat_left);

// [verif/rsq_trig_src.sv]
// Frame trigger source driving the trigger pin
module rsq_trig_src (
  // Clock
  input wire logic clk_sys,
  // Trigger pin
  output logic     trigger_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  initial trigger_pin = 1'b0;
  // Deliver n triggers, pin low for gap cycles after each
  task automatic fire(input int n, input int gap);
    repeat (n) begin
      @(negedge clk_sys);
      trigger_pin = 1'b1;
      repeat (5) @(negedge clk_sys);
      trigger_pin = 1'b0;
      repeat (gap) @(negedge clk_sys);
    end
  endtask
endmodule

// [verif/rsq_tb.sv]
// Self-checking bench for the sequence table stepper
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import rsq_pkg::*;
  logic          clk_sys, reset, clk_en, acq_start, op_busy, color_variant, trigger_pin;
  logic          next_cmd_valid, wr_en, wr_reject, frame_go, cap_lookup_en, acq_active;
  logic [1:0]    cap_column_merge, cap_row_merge;
  logic [3:0]    next_cmd_entry, table_entry_pick, cur_entry;
  logic [7:0]    seq_repeat, repeat_left;
  logic [9:0]    cap_black, blk_m;
  logic [11:0]   rd_height, rd_offset_y, cap_height, cap_offset_y;
  logic [12:0]   rd_width, rd_offset_x, cap_width, cap_offset_x;
  logic [15:0]   cap_gain_all, cap_gain_red, cap_gain_blue;
  logic [19:0]   cap_exposure, exp_m [10];
  logic [31:0]   seed = 32'h00000006;
  logic [47:0]   wr_data;
  rsq_mode_type  send_mode, mode_m;
  rsq_field_type wr_field;
  int            err_total, samples_checked, go_cnt, ptr_m, fc_m, cmd_m, e_m;
  int            cnt_m [10], link_m [10];
  rsq_mode_type  mode_list [2] = '{RSQ_MODE_NORMAL, RSQ_MODE_MULTI};
  rsq_sequencer dut_u (.clk_sys, .reset, .clk_en, .send_mode, .acq_start, .seq_repeat, .color_variant, .op_busy,
    .trigger_pin, .next_cmd_valid, .next_cmd_entry, .table_entry_pick, .wr_en, .wr_field, .wr_data, .wr_reject,
    .rd_width, .rd_height, .rd_offset_x, .rd_offset_y, .frame_go, .cur_entry, .cap_width, .cap_height,
    .cap_offset_x, .cap_offset_y, .cap_gain_all, .cap_gain_red, .cap_gain_blue, .cap_exposure, .cap_black,
    .cap_lookup_en, .cap_column_merge, .cap_row_merge, .acq_active, .repeat_left);
  rsq_trig_src src_u (.clk_sys, .trigger_pin);
  initial clk_sys = 1'b0;
  always #12.5 clk_sys = ~clk_sys;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Reference stepping: entry run by the next accepted trigger
  function automatic int step_model();
    int e;
    if (mode_m == RSQ_MODE_CMD_SEQ) return cmd_m;
    e = ptr_m;
    fc_m++;
    if (fc_m == cnt_m[e]) begin
      fc_m = 0;
      ptr_m = (link_m[e] == 15) ? 0 : link_m[e];
    end
    return e;
  endfunction
  always @(posedge clk_sys) begin
    if (frame_go === 1'b1) begin
      go_cnt++;
      e_m = step_model();
      check("cur_entry", cur_entry, e_m);
      @(posedge clk_sys);
      check("cap_exposure", cap_exposure, exp_m[e_m]);
    end
  end
  task automatic wr(input logic [3:0] p, input rsq_field_type f, input logic [47:0] d, input logic rej);
    @(negedge clk_sys);
    table_entry_pick = p;
    wr_field = f;
    wr_data = d;
    wr_en = 1'b1;
    @(negedge clk_sys);
    wr_en = 1'b0;
    check("wr_reject", wr_reject, rej);
  endtask
  task automatic start(input rsq_mode_type m, input logic [7:0] r);
    @(negedge clk_sys);
    send_mode = m;
    seq_repeat = r;
    acq_start = 1'b1;
    mode_m = m;
    ptr_m = 0;
    fc_m = 0;
    cmd_m = 0;
    @(negedge clk_sys);
    acq_start = 1'b0;
  endtask
  task automatic cmd(input logic [3:0] e);
    @(negedge clk_sys);
    next_cmd_valid = 1'b1;
    next_cmd_entry = e;
    @(negedge clk_sys);
    next_cmd_valid = 1'b0;
    if (e <= 4'h9) cmd_m = e;
  endtask
  task automatic expect_go(input int n);
    repeat (10) @(negedge clk_sys);
    check("frame count", go_cnt, n);
    go_cnt = 0;
  endtask
  initial begin
    repeat (5000) @(posedge clk_sys);
    err_total++;
    finish_test();
  end
  initial begin
    {reset, clk_en, color_variant} = 3'h7;
    {acq_start, op_busy, next_cmd_valid, wr_en, next_cmd_entry, table_entry_pick, seq_repeat} = '0;
    send_mode = RSQ_MODE_NORMAL;
    wr_field = RSQ_FLD_SIZE;
    wr_data = '0;
    for (int i = 0; i < 10; i++) begin
      cnt_m[i] = 1;
      link_m[i] = 0;
    end
    repeat (3) @(negedge clk_sys);
    reset = 1'b0;
    check("cap_width", cap_width, 13'h1400);
    check("cap_exposure", cap_exposure, 20'h2bf20);
    check("cap_merges", {cap_column_merge, cap_row_merge}, 4'h5);
    wr(4'h1, RSQ_FLD_SIZE, 48'h04000800, 1'b0);
    wr(4'h1, RSQ_FLD_SIZE, 48'h04000007, 1'b1);
    wr(4'h1, RSQ_FLD_SIZE, 48'h0f010800, 1'b1);
    wr(4'h1, RSQ_FLD_OFFSET, 48'h0b000c00, 1'b0);
    wr(4'h1, RSQ_FLD_OFFSET, 48'h00000c01, 1'b1);
    wr(4'h1, RSQ_FLD_OFFSET, 48'h0b010000, 1'b1);
    wr(4'h1, RSQ_FLD_OFFSET, 48'h00000000, 1'b0);
    wr(4'h1, RSQ_FLD_FLAGS, 48'h0000000c, 1'b0);
    wr(4'h1, RSQ_FLD_OFFSET, 48'h00000200, 1'b0);
    wr(4'h1, RSQ_FLD_OFFSET, 48'h00000201, 1'b1);
    @(negedge clk_sys);
    check("rd_offset_x", rd_offset_x, 13'h0200);
    check("rd_width", rd_width, 13'h0800);
    check("rd_height", rd_height, 12'h400);
    check("rd_offset_y", rd_offset_y, 12'h000);
    wr(4'h1, RSQ_FLD_FLAGS, 48'h00000012, 1'b0);
    wr(4'h1, RSQ_FLD_OFFSET, 48'h03800000, 1'b0);
    wr(4'h1, RSQ_FLD_OFFSET, 48'h03810000, 1'b1);
    wr(4'h1, RSQ_FLD_FLAGS, 48'h0000000e, 1'b1);
    wr(4'h1, RSQ_FLD_FLAGS, 48'h0000001a, 1'b1);
    wr(4'ha, RSQ_FLD_GAIN, 48'h00000001, 1'b1);
    wr(4'h0, RSQ_FLD_EXPOSURE, 48'h00000009, 1'b1);
    wr(4'h0, RSQ_FLD_STEP, 48'h00000300, 1'b1);
    wr(4'h0, RSQ_FLD_STEP, 48'h00000a02, 1'b1);
    for (int i = 0; i < 10; i++) begin
      exp_m[i] = 20'h0000a + 20'(rnd() & 32'h00000fff);
      wr(4'(i), RSQ_FLD_EXPOSURE, {28'h0000000, exp_m[i]}, 1'b0);
    end
    wr(4'h0, RSQ_FLD_STEP, 48'h00000302, 1'b0);
    wr(4'h3, RSQ_FLD_STEP, 48'h00000f01, 1'b0);
    {cnt_m[0], link_m[0], link_m[3]} = {32'd2, 32'd3, 32'd15};
    start(RSQ_MODE_TRIG_SEQ, 8'h02);
    src_u.fire(7, 10);
    expect_go(6);
    check("acq_active", acq_active, 1'b0);
    check("repeat_left", repeat_left, 8'h00);
    start(RSQ_MODE_TRIG_SEQ, 8'h01);
    op_busy = 1'b1;
    src_u.fire(1, 10);
    op_busy = 1'b0;
    expect_go(0);
    src_u.fire(1, 30);
    expect_go(1);
    start(RSQ_MODE_TRIG_SEQ, 8'h01);
    src_u.fire(1, 10);
    // A trigger while the clock enable is low must leave the count untouched
    clk_en = 1'b0;
    src_u.fire(1, 10);
    clk_en = 1'b1;
    src_u.fire(3, 10);
    expect_go(3);
    start(RSQ_MODE_CMD_SEQ, 8'h01);
    src_u.fire(1, 10);
    cmd(4'h7);
    src_u.fire(2, 10);
    cmd(4'hc);
    src_u.fire(1, 10);
    expect_go(4);
    blk_m = 10'(rnd());
    blk_m[9] = blk_m[8];
    wr(4'h5, RSQ_FLD_GAIN, 48'h000300020001, 1'b0);
    wr(4'h5, RSQ_FLD_BLACK, {38'h0, blk_m}, 1'b0);
    wr(4'h5, RSQ_FLD_FLAGS, 48'h0000000d, 1'b0);
    cmd(4'h5);
    src_u.fire(1, 10);
    expect_go(1);
    check("cap_gains", {cap_gain_blue, cap_gain_red, cap_gain_all}, 48'h000300020001);
    check("cap_black", cap_black, blk_m);
    check("cap_flags", {cap_lookup_en, cap_column_merge, cap_row_merge}, 5'h19);
    color_variant = 1'b0;
    wr(4'h1, RSQ_FLD_GAIN, 48'h000900080007, 1'b0);
    wr(4'h1, RSQ_FLD_OFFSET, 48'h03800100, 1'b0);
    cmd(4'h1);
    src_u.fire(1, 10);
    expect_go(1);
    check("cap_gains_mono", {cap_gain_blue, cap_gain_red, cap_gain_all}, 48'h000000000007);
    check("cap_size", {cap_width, cap_height}, {13'h0800, 12'h400});
    check("cap_offsets", {cap_offset_x, cap_offset_y}, {13'h0100, 12'h380});
    color_variant = 1'b1;
    foreach (mode_list[i]) begin
      start(mode_list[i], 8'h00);
      src_u.fire(1, 10);
      expect_go(0);
    end
    finish_test();
  end
endmodule
